/* File: inc/rtcmt_pkg.sv */
// package: register map, field layout, reset values and divider codes of the tick counter
package rtcmt_pkg;
  // register byte offsets on the wishbone bus
  localparam logic [3:0] STATUS_CONTROL_OFFSET = 4'h0;
  localparam logic [3:0] TICK_COUNT_OFFSET = 4'h4;
  localparam logic [3:0] COMPARE_LIMIT_OFFSET = 4'h8;
  // status_control_reg field positions
  localparam int MATCH_FLAG_BIT = 7;
  localparam int SOURCE_SELECT_HI = 6;
  localparam int SOURCE_SELECT_LO = 5;
  localparam int MATCH_IRQ_ENABLE_BIT = 4;
  localparam int DIVIDER_SELECT_HI = 3;
  localparam int DIVIDER_SELECT_LO = 0;
  // reset values
  localparam logic [7:0] COMPARE_LIMIT_RESET = 8'h00;
  localparam logic [7:0] TICK_COUNT_RESET = 8'h00;
  localparam logic [1:0] SOURCE_SELECT_RESET = 2'h0;
  localparam logic [3:0] DIVIDER_SELECT_RESET = 4'h0;
  localparam logic [3:0] DIVIDER_OFF = 4'h0;
  // source select codes
  localparam logic [1:0] SOURCE_LOW_POWER = 2'h0;
  localparam logic [1:0] SOURCE_EXTERNAL = 2'h1;
  // prescaler width: largest divide is 200000
  localparam int PRESCALE_WIDTH = 18;
  // answer for unmapped reads
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // divide value from divider code and source_select bit 0
  function automatic logic [PRESCALE_WIDTH-1:0] rtcmt_divide_value(
    input logic [3:0] code,
    input logic bigSet
  );
    logic [PRESCALE_WIDTH-1:0] val;
    val = '0;
    case ({bigSet, code})
      5'h01: val = 18'h00008;
      5'h02: val = 18'h00020;
      5'h03: val = 18'h00040;
      5'h04: val = 18'h00080;
      5'h05: val = 18'h00100;
      5'h06: val = 18'h00200;
      5'h07: val = 18'h00400;
      5'h08: val = 18'h00001;
      5'h09: val = 18'h00002;
      5'h0a: val = 18'h00004;
      5'h0b: val = 18'h0000a;
      5'h0c: val = 18'h00010;
      5'h0d: val = 18'h00064;
      5'h0e: val = 18'h001f4;
      5'h0f: val = 18'h003e8;
      5'h11: val = 18'h00400;
      5'h12: val = 18'h00800;
      5'h13: val = 18'h01000;
      5'h14: val = 18'h02000;
      5'h15: val = 18'h04000;
      5'h16: val = 18'h08000;
      5'h17: val = 18'h10000;
      5'h18: val = 18'h003e8;
      5'h19: val = 18'h007d0;
      5'h1a: val = 18'h01388;
      5'h1b: val = 18'h02710;
      5'h1c: val = 18'h04e20;
      5'h1d: val = 18'h0c350;
      5'h1e: val = 18'h186a0;
      5'h1f: val = 18'h30d40;
      default: val = '0;
    endcase
    return val;
  endfunction : rtcmt_divide_value
endpackage : rtcmt_pkg

/* File: hw/rtcmt_sync.sv */
// module: two flip-flop synchroniser plus rising edge detector for one source clock
`timescale 1ns/10ps
`default_nettype none
module rtcmt_sync
  import rtcmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic asyncIn,
  output logic risePulse
);
  logic stage1_q;
  logic stage2_q;
  logic stage3_q;

  // only stage2 and later are looked at, stage1 may be metastable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // one-cycle pulse per source rising edge
  assign risePulse = stage2_q & ~stage3_q;
endmodule : rtcmt_sync
`default_nettype wire

/* File: hw/rtcmt_prescaler.sv */
// module: programmable prescaler counting source edges into one tick per divide period
`timescale 1ns/10ps
`default_nettype none
module rtcmt_prescaler
  import rtcmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic srcEdge,
  input wire logic run,
  input wire logic clear,
  input wire logic [PRESCALE_WIDTH-1:0] divideValue,
  output logic tick
);
  logic [PRESCALE_WIDTH-1:0] count_q;
  logic lastCount;

  // divide of zero means off
  assign lastCount = (count_q == divideValue - 18'h00001);
  assign tick = run && srcEdge && (divideValue != '0) && lastCount;

  // count source edges; clear wins over everything
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
    end else if (clear || divideValue == '0) begin
      count_q <= '0;
    end else if (run && srcEdge) begin
      count_q <= lastCount ? '0 : count_q + 18'h00001;
    end
  end
endmodule : rtcmt_prescaler
`default_nettype wire

/* File: hw/rtcmt_counter.sv */
// module: wishbone real-time tick counter with selectable source, prescaler and modulo compare
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - one 8-bit up-counter and one 8-bit compare value, clocked via prescaler
// - counter steps at prescaled rate, after equalling compare returns to zero
// - compare value accepts every value from zero to all ones
// - match flag sets on the step from compare value to zero
// - compare of zero sets the flag on every prescaler tick
// - any compare write clears prescaler and counter
// - reset stops counter at zero, compare zero, prescaler off, low power source
// - divider code zero keeps prescaler off; nonzero code starts counting
// - source code 00 low power, 01 external, 1x internal reference
// - writing a different source code clears prescaler and counter
// - writing a different divider code clears prescaler and counter
// - divide value chosen by divider code and source bit 0
// - low power source: codes give 8 ms up to 1.024 s, 1111 gives 1 s
// - external 1 MHz: 0001 gives 1.024 ms, 1000 gives 1 ms, 1111 0.2 s
// - internal 32 kHz: 0001 gives 250 us, or 32 ms with larger set
// - interrupt request while match flag and enable are both set
// - writing one to match flag clears it and withdraws the request
// - writing zero leaves flag; reset clears flag, enable, source, divider
// - binary and decimal divide tables for both halves of the divide set
// - counter readable by software, writes to it ignored
// - counting held during debug halt, resumes unless settings changed
module rtcmt_counter
  import rtcmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic lowPowerOscClock,
  input wire logic externalRefClock,
  input wire logic internalRefClock,
  input wire logic debugHalt,
  output logic matchIrq
);
  logic [7:0] tickCount_q;
  logic [7:0] compareLimit_q;
  logic [1:0] sourceSelect_q;
  logic [3:0] dividerSelect_q;
  logic matchIrqEnable_q;
  logic matchFlag_q;
  logic ack_q;
  logic [31:0] readData_q;
  logic irq_q;
  logic debugMeta_q;
  logic debugHalt_q;
  logic lowPowerEdge;
  logic externalEdge;
  logic internalEdge;
  logic srcEdge;
  logic prescaleTick;
  logic access;
  logic writeStrobe;
  logic writeStatus;
  logic writeCompare;
  logic sourceChange;
  logic dividerChange;
  logic clearCounters;
  logic matchEvent;
  logic [7:0] statusByte;
  logic [PRESCALE_WIDTH-1:0] divideValue;

  // each source is asynchronous to the bus clock; sampled then edge detected
  rtcmt_sync lowPowerSync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn(lowPowerOscClock),
    .risePulse(lowPowerEdge)
  );

  rtcmt_sync externalSync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn(externalRefClock),
    .risePulse(externalEdge)
  );

  rtcmt_sync internalSync (
    .clock(clock),
    .arst_n(arst_n),
    .asyncIn(internalRefClock),
    .risePulse(internalEdge)
  );

  // source mux on synchronised edges, avoids glitchy clock muxing
  always_comb begin
    case (sourceSelect_q)
      SOURCE_LOW_POWER: srcEdge = lowPowerEdge;
      SOURCE_EXTERNAL: srcEdge = externalEdge;
      default: srcEdge = internalEdge;
    endcase
  end

  // debug halt comes from another domain, synchronised too
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      debugMeta_q <= 1'b0;
      debugHalt_q <= 1'b0;
    end else begin
      debugMeta_q <= debugHalt;
      debugHalt_q <= debugMeta_q;
    end
  end

  // bus decode; ack is one cycle, so cyc/stb must drop before the next access
  assign access = wb_cyc_i && wb_stb_i && !ack_q;
  assign writeStrobe = access && wb_we_i && wb_sel_i[0];
  assign writeStatus = writeStrobe && (wb_adr_i == STATUS_CONTROL_OFFSET);
  assign writeCompare = writeStrobe && (wb_adr_i == COMPARE_LIMIT_OFFSET);

  // only a differing source or divider code restarts the chain; a compare write always does
  assign sourceChange = writeStatus &&
    (wb_dat_i[SOURCE_SELECT_HI:SOURCE_SELECT_LO] != sourceSelect_q);
  assign dividerChange = writeStatus &&
    (wb_dat_i[DIVIDER_SELECT_HI:DIVIDER_SELECT_LO] != dividerSelect_q);
  assign clearCounters = writeCompare || sourceChange || dividerChange;

  // binary and decimal divide sets, the upper half picked by source bit 0
  assign divideValue = rtcmt_divide_value(dividerSelect_q,
    sourceSelect_q[0]);

  // table covers every period of the four source columns
  rtcmt_prescaler prescaler (
    .clock(clock),
    .arst_n(arst_n),
    .srcEdge(srcEdge),
    .run(!debugHalt_q),
    .clear(clearCounters),
    .divideValue(divideValue),
    .tick(prescaleTick)
  );

  // a match is the tick that takes the count from compare value back to zero
  // with a compare of zero the count never leaves zero, so every tick matches
  assign matchEvent = prescaleTick &&
    (tickCount_q == compareLimit_q);

  // main counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tickCount_q <= TICK_COUNT_RESET;
    end else if (clearCounters) begin
      tickCount_q <= TICK_COUNT_RESET;
    end else if (matchEvent) begin
      tickCount_q <= TICK_COUNT_RESET;
    end else if (prescaleTick) begin
      tickCount_q <= tickCount_q + 8'h01;
    end
  end

  // compare register, any byte value allowed
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      compareLimit_q <= COMPARE_LIMIT_RESET;
    end else if (writeCompare) begin
      compareLimit_q <= wb_dat_i[7:0];
    end
  end

  // control fields of status_control_reg
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sourceSelect_q <= SOURCE_SELECT_RESET;
      dividerSelect_q <= DIVIDER_SELECT_RESET;
      matchIrqEnable_q <= 1'b0;
    end else if (writeStatus) begin
      sourceSelect_q <= wb_dat_i[SOURCE_SELECT_HI:SOURCE_SELECT_LO];
      dividerSelect_q <= wb_dat_i[DIVIDER_SELECT_HI:DIVIDER_SELECT_LO];
      matchIrqEnable_q <= wb_dat_i[MATCH_IRQ_ENABLE_BIT];
    end
  end

  // match flag: set beats the write-one clear so no event is lost
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      matchFlag_q <= 1'b0;
    end else if (matchEvent) begin
      matchFlag_q <= 1'b1;
    end else if (writeStatus && wb_dat_i[MATCH_FLAG_BIT]) begin
      matchFlag_q <= 1'b0;
    end
  end

  // request registered one cycle after flag and enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= matchFlag_q && matchIrqEnable_q;
    end
  end

  assign statusByte = {matchFlag_q, sourceSelect_q, matchIrqEnable_q, dividerSelect_q};

  // read data and ack; counter register is read only
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      readData_q <= UNMAPPED_READ;
    end else begin
      ack_q <= access;
      if (access && !wb_we_i) begin
        case (wb_adr_i)
          STATUS_CONTROL_OFFSET: readData_q <= {24'h000000, statusByte};
          TICK_COUNT_OFFSET: readData_q <= {24'h000000, tickCount_q};
          COMPARE_LIMIT_OFFSET: readData_q <= {24'h000000, compareLimit_q};
          default: readData_q <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = readData_q;
  assign matchIrq = irq_q;
endmodule : rtcmt_counter
`default_nettype wire

/* File: verification/rtcmt_counter_properties.sv */
// checker: bus timing, read-back and interrupt properties of the tick counter
`timescale 1ns/10ps
`default_nettype none
module rtcmt_counter_checker
  import rtcmt_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic matchIrq
);
  logic [6:0] statShadow_q;
  logic [7:0] cmpShadow_q;
  logic enPrev_q;
  logic take;
  logic rdAck;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rdAck = wb_ack_o && !wb_we_i;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // mirror of written settings; a write lands on the edge that takes it
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      statShadow_q <= 7'h00;
      cmpShadow_q <= 8'h00;
    end else if (take && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == STATUS_CONTROL_OFFSET) statShadow_q <= wb_dat_i[6:0];
      if (wb_adr_i == COMPARE_LIMIT_OFFSET) cmpShadow_q <= wb_dat_i[7:0];
    end
  end
  // enable one cycle back, because the request output is registered
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) enPrev_q <= 1'b0;
    else enPrev_q <= statShadow_q[MATCH_IRQ_ENABLE_BIT];
  end
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  irq_after_reset_a: assert property ($rose(arst_n) |-> !matchIrq && !wb_ack_o)
    else $error("outputs active after reset");
  irq_needs_enable_a: assert property (!enPrev_q |-> !matchIrq)
    else $error("interrupt raised while disabled");
  read_upper_zero_a: assert property (rdAck |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  unmapped_read_a: assert property (rdAck && wb_adr_i != STATUS_CONTROL_OFFSET
    && wb_adr_i != TICK_COUNT_OFFSET && wb_adr_i != COMPARE_LIMIT_OFFSET
    |-> wb_dat_o == UNMAPPED_READ) else $error("unmapped read not zero");
  compare_readback_a: assert property (rdAck && wb_adr_i == COMPARE_LIMIT_OFFSET
    |-> wb_dat_o[7:0] == cmpShadow_q) else $error("compare read-back wrong");
  status_readback_a: assert property (rdAck && wb_adr_i == STATUS_CONTROL_OFFSET
    |-> wb_dat_o[6:0] == statShadow_q) else $error("status read-back wrong");
  off_count_zero_a: assert property (rdAck && wb_adr_i == TICK_COUNT_OFFSET
    && statShadow_q[3:0] == DIVIDER_OFF |-> wb_dat_o[7:0] == 8'h00)
    else $error("count moved with divider off");
  cover property (rdAck && wb_adr_i == TICK_COUNT_OFFSET && wb_dat_o[7:0] != 8'h00);
  cover property (matchIrq);
  cover property (take && wb_we_i && wb_adr_i == COMPARE_LIMIT_OFFSET);
endmodule : rtcmt_counter_checker
bind rtcmt_counter rtcmt_counter_checker rtcmt_counter_checker_i (.clock(clock),
  .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .matchIrq(matchIrq));
`default_nettype wire

/* File: verification/tb.sv */
// testbench: bus access, counting, match flag and interrupt of the tick counter
`timescale 1ns/10ps
`default_nettype none
module tb;
  import rtcmt_pkg::*;
  localparam logic [3:0] SC = STATUS_CONTROL_OFFSET;
  localparam logic [3:0] TC = TICK_COUNT_OFFSET;
  localparam logic [3:0] CL = COMPARE_LIMIT_OFFSET;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbAdr = 4'h0;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic wbAck;
  logic [2:0] srcClk = 3'h0;
  logic debugHalt = 1'b0;
  logic matchIrq;
  logic [7:0] rnd;
  logic [31:0] expQ[$];
  logic [3:0] adrQ[$];
  int err_count = 0;
  int check_count = 0;
  rtcmt_counter rtcmt_counter_i (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .lowPowerOscClock(srcClk[0]),
    .externalRefClock(srcClk[1]), .internalRefClock(srcClk[2]), .debugHalt(debugHalt),
    .matchIrq(matchIrq));
  // 100 ns bus clock
  initial begin
    forever #50 clock = ~clock;
  end
  // one classic cycle; holds everything until ack is seen
  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] d);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hf;
    wbDatW <= {24'h0, d};
    @(posedge clock);
    while (wbAck !== 1'b1) @(posedge clock);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] adr, input logic [7:0] e);
    expQ.push_back({24'h0, e});
    adrQ.push_back(adr);
    bus(1'b0, adr, 8'h00);
  endtask : rd
  // slow source pulses so the two-flop sampling never misses one
  task automatic edges(input int src, input int n);
    repeat (n) begin
      @(posedge clock) srcClk[src] <= 1'b1;
      repeat (3) @(posedge clock);
      srcClk[src] <= 1'b0;
      repeat (3) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask : edges
  task automatic chkIrq(input logic e);
    check_count++;
    if (matchIrq !== e) begin
      err_count++;
      $display("ERROR matchIrq expected %b seen %b", e, matchIrq);
    end
  endtask : chkIrq
  task automatic results();
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  // oldest note against each read answer
  always @(posedge clock) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      check_count++;
      if (wbDatR !== expQ[0]) begin
        err_count++;
        $display("ERROR reg %h expected %h seen %h", adrQ[0], expQ[0], wbDatR);
      end
      void'(expQ.pop_front());
      void'(adrQ.pop_front());
    end
  end
  initial begin
    void'($urandom(62));
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    rd(SC, 8'h00);
    rd(CL, 8'h00);
    edges(0, 2);
    rd(TC, 8'h00);
    rnd = 8'($urandom);
    bus(1'b1, CL, rnd);
    rd(CL, rnd);
    bus(1'b1, CL, 8'hff);
    rd(CL, 8'hff);
    bus(1'b1, TC, 8'h5a);
    rd(TC, 8'h00);
    rd(4'hc, 8'h00);
    bus(1'b1, CL, 8'h02);
    bus(1'b1, SC, 8'h08);
    edges(0, 2);
    rd(TC, 8'h02);
    rd(SC, 8'h08);
    edges(0, 1);
    rd(TC, 8'h00);
    rd(SC, 8'h88);
    bus(1'b1, SC, 8'h18);
    rd(SC, 8'h98);
    chkIrq(1'b1);
    bus(1'b1, SC, 8'h98);
    rd(SC, 8'h18);
    chkIrq(1'b0);
    edges(0, 1);
    bus(1'b1, SC, 8'h19);
    rd(TC, 8'h00);
    edges(0, 3);
    rd(TC, 8'h01);
    edges(1, 2);
    rd(TC, 8'h01);
    bus(1'b1, SC, 8'h29);
    edges(1, 4);
    rd(TC, 8'h00);
    bus(1'b1, SC, 8'h49);
    edges(2, 3);
    rd(TC, 8'h01);
    debugHalt <= 1'b1;
    edges(2, 4);
    rd(TC, 8'h01);
    debugHalt <= 1'b0;
    edges(2, 2);
    rd(TC, 8'h02);
    bus(1'b1, CL, 8'h00);
    rd(TC, 8'h00);
    bus(1'b1, SC, 8'h48);
    edges(2, 1);
    rd(SC, 8'hc8);
    bus(1'b1, SC, 8'hc8);
    edges(2, 1);
    rd(SC, 8'hc8);
    bus(1'b1, CL, 8'h05);
    bus(1'b1, SC, 8'h41);
    edges(2, 8);
    rd(TC, 8'h01);
    bus(1'b1, SC, 8'h61);
    edges(2, 8);
    rd(TC, 8'h00);
    rd(SC, 8'he1);
    // mid-run reset must bring every setting back to its reset value
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rd(SC, 8'h00);
    rd(CL, 8'h00);
    results();
  end
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    #2000000;
    err_count++;
    results();
  end
endmodule : tb
`default_nettype wire
